// *** sim/tb_tcs_clock_ctrl.sv ***
// self-checking bench for the timer clock control block
`timescale 1ns/1ps
module tb_tcs_clock_ctrl;
	import tcs_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	tcs_bus_req_t req = '0;
	logic [1:0][2:0] cs = '0;
	logic acs = 1'b0;
	logic ce = 1'b1;
	logic run_p = 1'b0;
	logic run_x = 1'b0;
	int half_p = 3;
	logic xp, xt, hit, hold, rs_sh, rs_as;
	logic [7:0] rdata;
	logic [8:0] got;
	logic [9:0] psc, apsc;
	tcs_ticks_t tk;
	int n_tick [3] = '{0, 0, 0};
	int err_total = 0;
	int comparisons = 0;
	always #2.5 clk = ~clk;
	tcs_clock_ctrl uut (.clk(clk), .rst(rst), .ce(ce), .bus_req(req), .bus_rdata_q(rdata),
		.bus_hit_q(hit), .ext_count_clock_pin({2{xp}}), .clock_select_field(cs),
		.xtal_osc_pin_a(xt), .async_clock_select(acs), .ticks_q(tk), .shared_prescale_q(psc),
		.async_prescale_q(apsc), .sync_hold_mode_q(hold), .shared_prescaler_reset_q(rs_sh),
		.async_prescaler_reset_q(rs_as));
	tcs_ext_src u_pin (.clk(clk), .run(run_p), .half(half_p), .pin(xp));
	tcs_ext_src u_xtal (.clk(clk), .run(run_x), .half(4), .pin(xt));
	// tallies on the falling edge, clear of register updates
	always @(negedge clk) begin
		n_tick[0] += tk.sync_tick[0];
		n_tick[1] += tk.sync_tick[1];
		n_tick[2] += tk.async_tick;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one access; idle cycle after so strobes never retoggle in one step
	task automatic bus(input logic io, input logic [7:0] a, input logic w, input logic [7:0] d);
		req = '{addr: a, io_space: io, wr: w, rd: !w, wdata: d};
		cyc(1);
		got = {hit, rdata};
		req = '0;
		cyc(1);
	endtask
	task automatic t_regs;
		bus(1'b0, 8'h43, 1'b0, 8'h00);
		chk(got, 9'h100);
		bus(1'b1, 8'h43, 1'b0, 8'h00);
		chk(got, 9'h000);
		bus(1'b0, 8'h44, 1'b1, 8'hFF);
		bus(1'b1, 8'h23, 1'b1, 8'hFF);
		cyc(4);
		bus(1'b1, 8'h23, 1'b0, 8'h00);
		chk(got, 9'h183);
		bus(1'b0, 8'h43, 1'b1, 8'h00);
		chk({hold, rs_as, rs_sh}, 3'h0);
	endtask
	task automatic t_presc;
		bus(1'b0, 8'h43, 1'b1, 8'h01);
		chk({rs_sh, psc}, 11'h000);
		cyc(1);
		chk(psc, 10'h001);
	endtask
	// clock enable low freezes the free-running prescaler
	task automatic t_ce;
		logic [9:0] p;
		p = psc;
		ce = 1'b0;
		cyc(5);
		chk(psc, p);
		ce = 1'b1;
		cyc(1);
		chk(psc, 10'(p + 10'h001));
	endtask
	task automatic t_taps;
		int div [6] = '{0, 1, 8, 64, 256, 1024};
		for (int c = 0; c < 6; c++) begin
			// select moves only while the pin is still
			cs = {2{3'(c)}};
			cyc(2);
			n_tick = '{0, 0, 0};
			cyc(2048);
			chk(16'(n_tick[0]), div[c] == 0 ? 16'h0000 : 16'(2048 / div[c]));
			chk(16'(n_tick[2]), 16'h0800);
		end
	endtask
	task automatic t_ext;
		cs = {TCS_CS_EXT_FALL, TCS_CS_EXT_RISE};
		for (int h = 3; h <= 5; h += 2) begin
			half_p = h;
			cyc(2);
			n_tick = '{0, 0, 0};
			run_p = 1'b1;
			cyc(60);
			run_p = 1'b0;
			cyc(6);
			chk(16'(n_tick[0]), 16'(30 / h));
			chk(16'(n_tick[1]), 16'(30 / h));
		end
	endtask
	task automatic t_async;
		bus(1'b0, 8'h43, 1'b1, 8'h02);
		chk(rs_as, 1'b0);
		chk(apsc, 10'h000);
		cyc(1);
		chk(apsc, 10'h001);
		acs = 1'b1;
		cyc(2);
		bus(1'b0, 8'h43, 1'b1, 8'h02);
		cyc(20);
		chk(rs_as, 1'b1);
		run_x = 1'b1;
		cyc(40);
		chk(rs_as, 1'b0);
		n_tick = '{0, 0, 0};
		cyc(40);
		run_x = 1'b0;
		cyc(6);
		chk(16'(n_tick[2]), 16'h0005);
		chk(apsc, 10'h009);
	endtask
	task automatic close_out;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		cyc(2);
		t_regs();
		t_presc();
		t_ce();
		t_taps();
		t_ext();
		t_async();
		close_out();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		close_out();
	end
endmodule

// *** sim/tcs_ext_src.sv ***
// stand-in for the external count clock or the watch crystal on a pin
`timescale 1ns/1ps
module tcs_ext_src (
	input wire logic clk,
	input wire logic run,
	input wire integer half,
	output logic pin
);
	int cnt;
	logic nxt;
	initial begin
		pin = 1'b0;
		nxt = 1'b0;
		cnt = 0;
	end
	// half periods of whole cycles
	// run and half are read at the edge, the pin moves just after it
	always @(posedge clk) begin
		nxt = pin;
		cnt = run ? cnt + 1 : 0;
		if (cnt >= half) begin
			cnt = 0;
			nxt = ~pin;
		end
		#1;
		pin = nxt;
	end
endmodule

// *** sim/tcs_monitor.sv ***
// assertion checker for the timer clock control block
`timescale 1ns/1ps
module tcs_monitor
	import tcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire tcs_bus_req_t bus_req,
	input wire logic bus_hit_q,
	input wire logic [TCS_NUM_SYNC_TIMERS-1:0] ext_count_clock_pin,
	input wire logic [TCS_NUM_SYNC_TIMERS-1:0][2:0] clock_select_field,
	input wire logic xtal_osc_pin_a,
	input wire logic async_clock_select,
	input wire tcs_ticks_t ticks_q,
	input wire logic [TCS_PRESC_W-1:0] shared_prescale_q,
	input wire logic sync_hold_mode_q,
	input wire logic shared_prescaler_reset_q,
	input wire logic async_prescaler_reset_q
);
	// decode of a request in either address view
	wire logic hit = ce && (bus_req.rd || bus_req.wr) && (bus_req.io_space ?
		bus_req.addr == TCS_CTRL_IO_OFFSET : bus_req.addr == TCS_CTRL_DATA_OFFSET);
	wire logic wr_hit = hit && bus_req.wr;
	wire logic [2:0] cs0 = clock_select_field[0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_ext_rise: assert property ($rose(ext_count_clock_pin[0]) && cs0 == TCS_CS_EXT_RISE
		|-> ##[1:2] ticks_q.sync_tick[0]) else $error("rise tick missing");
	a_ext_fall: assert property ($fell(ext_count_clock_pin[1])
		&& clock_select_field[1] == TCS_CS_EXT_FALL |-> ##[1:2] ticks_q.sync_tick[1])
		else $error("fall tick missing");
	a_no_source: assert property ($past(cs0) == TCS_CS_NONE |-> !ticks_q.sync_tick[0])
		else $error("tick without source");
	a_hold_keep: assert property (sync_hold_mode_q && !wr_hit |=>
		$stable(shared_prescaler_reset_q) && $stable(async_prescaler_reset_q))
		else $error("reset bit moved in hold");
	a_hold_release: assert property (wr_hit && bus_req.wdata == 8'h00 |=>
		!sync_hold_mode_q && !shared_prescaler_reset_q && !async_prescaler_reset_q)
		else $error("release left bits set");
	a_shared_zero: assert property (shared_prescaler_reset_q |=>
		shared_prescale_q == TCS_PRESC_RESET) else $error("prescaler not cleared");
	a_async_keep: assert property (async_clock_select && async_prescaler_reset_q
		&& !wr_hit && xtal_osc_pin_a == $past(xtal_osc_pin_a, 1)
		&& xtal_osc_pin_a == $past(xtal_osc_pin_a, 3) && $past(xtal_osc_pin_a, 2)
		== xtal_osc_pin_a |=> async_prescaler_reset_q) else $error("async bit cleared early");
	a_decode_hit: assert property (ce && (bus_req.rd || bus_req.wr) |=>
		bus_hit_q == $past(hit)) else $error("decode wrong");
endmodule
bind tcs_clock_ctrl tcs_monitor u_mon (.clk, .rst, .ce, .bus_req, .bus_hit_q,
	.ext_count_clock_pin, .clock_select_field, .xtal_osc_pin_a, .async_clock_select,
	.ticks_q, .shared_prescale_q, .sync_hold_mode_q, .shared_prescaler_reset_q,
	.async_prescaler_reset_q);

// *** verilog/tcs_clock_ctrl.sv ***
// timer clock source selection, shared prescaler and its control register
//
// How it works
// - external edge reaches counter in 2.5-3.5 cycles
// - external edges bypass the prescaler entirely
// - sync hold keeps both reset bits written
// - clearing sync hold with a zero write clears both reset bits
// - async reset bit resets async prescaler
// - async mode: bit stays until reset done
// - shared reset bit resets shared prescaler
// - register decodes at data and I/O offsets
// - async clock is clk or crystal when selected
// - no source selected gives no ticks
// - sample pins each cycle, pick edge polarity
// - shared prescaler taps 8, 64, 256, 1024
`timescale 1ns/1ps
module tcs_clock_ctrl
	import tcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire tcs_bus_req_t bus_req,
	output logic [7:0] bus_rdata_q,
	output logic bus_hit_q,
	input wire logic [TCS_NUM_SYNC_TIMERS-1:0] ext_count_clock_pin,
	input wire logic [TCS_NUM_SYNC_TIMERS-1:0][2:0] clock_select_field,
	input wire logic xtal_osc_pin_a,
	input wire logic async_clock_select,
	output tcs_ticks_t ticks_q,
	output logic [TCS_PRESC_W-1:0] shared_prescale_q,
	output logic [TCS_PRESC_W-1:0] async_prescale_q,
	output logic sync_hold_mode_q,
	output logic shared_prescaler_reset_q,
	output logic async_prescaler_reset_q
);

	logic hit;
	logic ctrl_wr;
	logic ctrl_rd;
	logic wr_hold;
	logic wr_async_psr;
	logic wr_shared_psr;
	logic [TCS_PRESC_W-1:0] shared_presc_d;
	logic [TCS_NUM_TAPS-1:0] tap_hit;
	logic [TCS_NUM_SYNC_TIMERS-1:0] ext_rise;
	logic [TCS_NUM_SYNC_TIMERS-1:0] ext_fall;
	logic [TCS_NUM_SYNC_TIMERS-1:0] sync_tick_d;
	logic xtal_rise;
	logic async_src_tick;
	logic async_reset_done;
	logic async_psr_d;
	logic shared_psr_d;
	logic [TCS_PRESC_W-1:0] async_presc_d;
	logic [7:0] ctrl_image;
	logic [TCS_NUM_SYNC_TIMERS-1:0] sync_tick_q;
	logic async_tick_q;

	// decode at both address views
	// the I/O view is the data-space offset less the I/O shift
	// the same register answers the data-space offset and the I/O-space one
	assign hit = bus_req.io_space ? (bus_req.addr == TCS_CTRL_IO_OFFSET)
		: (bus_req.addr == TCS_CTRL_DATA_OFFSET);
	assign ctrl_wr = hit & bus_req.wr;
	assign ctrl_rd = hit & bus_req.rd;
	assign wr_hold = bus_req.wdata[TCS_BIT_SYNC_HOLD];
	assign wr_async_psr = bus_req.wdata[TCS_BIT_ASYNC_PSR];
	assign wr_shared_psr = bus_req.wdata[TCS_BIT_SHARED_PSR];

	// read image; unused bits read as zero
	always_comb begin
		ctrl_image = TCS_CTRL_RESET;
		ctrl_image[TCS_BIT_SYNC_HOLD] = sync_hold_mode_q;
		ctrl_image[TCS_BIT_ASYNC_PSR] = async_prescaler_reset_q;
		ctrl_image[TCS_BIT_SHARED_PSR] = shared_prescaler_reset_q;
	end

	// bus answer flag, one cycle after any decoded strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_hit_q <= 1'b0;
		end else if (ce) begin
			bus_hit_q <= hit & (bus_req.rd | bus_req.wr);
		end
	end

	// read data register, one cycle after the read strobe
	// unmapped addresses and non-read cycles return zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_rdata_q <= TCS_RDATA_RESET;
		end else if (ce) begin
			if (ctrl_rd) begin
				bus_rdata_q <= ctrl_image;
			end else begin
				bus_rdata_q <= TCS_RDATA_RESET;
			end
		end
	end

	// synchronisation hold bit, plain read/write storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_hold_mode_q <= 1'b0;
		end else if (ce) begin
			if (ctrl_wr) begin
				sync_hold_mode_q <= wr_hold;
			end
		end
	end

	// next value of the shared prescaler reset bit
	always_comb begin
		shared_psr_d = 1'b0;
		// a write wins over any hardware clear in the same cycle
		if (ctrl_wr) begin
			// written zero hold clears
			// the written bit still gives one cycle of reset when hold is off
			shared_psr_d = wr_shared_psr;
		end else if (sync_hold_mode_q) begin
			shared_psr_d = shared_prescaler_reset_q;
		end else begin
			shared_psr_d = 1'b0;
		end
	end

	// shared prescaler reset bit storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shared_prescaler_reset_q <= 1'b0;
		end else if (ce) begin
			shared_prescaler_reset_q <= shared_psr_d;
		end
	end

	// async source selection
	// the crystal is sampled like any pin; this limits it to below clk/2,
	// which a watch crystal easily meets
	assign async_src_tick = async_clock_select ? xtal_rise : 1'b1;

	// reset completes on source tick
	// in synchronous operation every cycle is a source tick, so the bit
	// drops at once; on the crystal it waits for the next rising crystal edge
	assign async_reset_done = async_src_tick;

	// next value of the async prescaler reset bit
	always_comb begin
		async_psr_d = 1'b0;
		// as for the shared bit, a write wins over the hardware clear
		if (ctrl_wr) begin
			async_psr_d = wr_async_psr;
		end else if (sync_hold_mode_q) begin
			async_psr_d = async_prescaler_reset_q;
		end else if (async_prescaler_reset_q & ~async_reset_done) begin
			async_psr_d = 1'b1;
		end else begin
			async_psr_d = 1'b0;
		end
	end

	// async prescaler reset bit storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			async_prescaler_reset_q <= 1'b0;
		end else if (ce) begin
			async_prescaler_reset_q <= async_psr_d;
		end
	end

	// shared prescaler counter
	// free running, independent of any timer's clock select
	always_comb begin
		if (shared_prescaler_reset_q) begin
			shared_presc_d = TCS_PRESC_RESET;
		end else begin
			shared_presc_d = shared_prescale_q + TCS_PRESC_W'(1);
		end
	end

	// shared prescaler storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shared_prescale_q <= TCS_PRESC_RESET;
		end else if (ce) begin
			shared_prescale_q <= shared_presc_d;
		end
	end

	// divide taps from prescaler
	// a tap fires on the count where its low bits are all ones
	// taps are gated during a prescaler reset so no stale tick escapes
	genvar t;
	generate
		for (t = 0; t < TCS_NUM_TAPS; t++) begin : g_tap
			localparam logic [TCS_PRESC_W-1:0] TAP_MASK =
				TCS_PRESC_W'((1 << TCS_TAP_BITS[t]) - 1);
			assign tap_hit[t] = ~shared_prescaler_reset_q
				& ((shared_prescale_q & TAP_MASK) == TAP_MASK);
		end
	endgenerate

	// per-timer pin sampling and clock selection
	genvar i;
	generate
		for (i = 0; i < TCS_NUM_SYNC_TIMERS; i++) begin : g_timer
			logic tick_sel;

			// each timer has its own pin and its own edge detector
			// sample pin every cycle
			tcs_pin_edge u_edge (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.pin(ext_count_clock_pin[i]),
				.rise(ext_rise[i]),
				.fall(ext_fall[i])
			);

			// select one tick source for this timer
			always_comb begin
				tick_sel = 1'b0;
				unique case (clock_select_field[i])
					TCS_CS_NONE: tick_sel = 1'b0;
					// undivided clock is also held off during a prescaler reset,
					// so a held timer cannot advance
					TCS_CS_DIV1: tick_sel = ~shared_prescaler_reset_q;
					TCS_CS_DIV8: tick_sel = tap_hit[0];
					TCS_CS_DIV64: tick_sel = tap_hit[1];
					TCS_CS_DIV256: tick_sel = tap_hit[2];
					TCS_CS_DIV1024: tick_sel = tap_hit[3];
					TCS_CS_EXT_FALL: tick_sel = ext_fall[i];
					TCS_CS_EXT_RISE: tick_sel = ext_rise[i];
				endcase
			end
			// one bit per timer into the shared vector
			assign sync_tick_d[i] = tick_sel;
		end
	endgenerate

	// crystal pin sampler for the asynchronous timer source
	// only rising crystal edges feed the async source; the fall output is unused
	tcs_pin_edge u_xtal_edge (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin(xtal_osc_pin_a),
		.rise(xtal_rise),
		.fall()
	);

	// registered tick output
	// pin edge to tick: half stage, sample, compare, this flop, 1.5 to 2.5
	// cycles; are the driver's side and not checked here
	// a tick stands one cycle; the timer counts it at the next edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_tick_q <= '0;
		end else if (ce) begin
			sync_tick_q <= sync_tick_d;
		end
	end

	// async prescaler: counts source ticks, cleared by its reset bit
	always_comb begin
		async_presc_d = async_prescale_q;
		if (async_prescaler_reset_q) begin
			async_presc_d = TCS_PRESC_RESET;
		end else if (async_src_tick) begin
			async_presc_d = async_prescale_q + TCS_PRESC_W'(1);
		end
	end

	// async prescaler storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			async_prescale_q <= TCS_PRESC_RESET;
		end else if (ce) begin
			async_prescale_q <= async_presc_d;
		end
	end

	// async tick output
	// the tick is suppressed while the reset bit is set so the timer halts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			async_tick_q <= 1'b0;
		end else if (ce) begin
			async_tick_q <= async_src_tick & ~async_prescaler_reset_q;
		end
	end

	// tick bundle handed to the timer counters, straight from the flops
	assign ticks_q = '{sync_tick: sync_tick_q, async_tick: async_tick_q};

endmodule

// *** verilog/tcs_pin_edge.sv ***
// pin sampler: half-cycle stage, synchroniser flop and edge compare
`timescale 1ns/1ps
module tcs_pin_edge
	import tcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic pin,
	output logic rise,
	output logic fall
);

	logic half_q;
	logic samp_q;
	logic prev_q;

	// half-cycle capture stage
	// stands in for a latch open while clk is high: the value it holds at the
	// falling edge is what a latch would present to the next rising edge
	always_ff @(negedge clk or posedge rst) begin
		if (rst) begin
			half_q <= 1'b0;
		end else if (ce) begin
			half_q <= pin;
		end
	end

	// rising-edge sample chain
	// half_q is read only by samp_q, so metastability stays inside the chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			samp_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (ce) begin
			samp_q <= half_q;
			prev_q <= samp_q;
		end
	end

	assign rise = samp_q & ~prev_q;
	assign fall = ~samp_q & prev_q;

endmodule

// *** verilog/tcs_pkg.sv ***
// shared constants and types for the timer clock source and prescaler control
package tcs_pkg;

	// control register placement, data space and I/O space views
	localparam logic [7:0] TCS_CTRL_DATA_OFFSET = 8'h43;
	localparam logic [7:0] TCS_IO_SPACE_SHIFT = 8'h20;
	localparam logic [7:0] TCS_CTRL_IO_OFFSET = TCS_CTRL_DATA_OFFSET - TCS_IO_SPACE_SHIFT;
	localparam logic [7:0] TCS_CTRL_RESET = 8'h00;

	// control register field positions
	localparam int TCS_BIT_SYNC_HOLD = 7;
	localparam int TCS_BIT_ASYNC_PSR = 1;
	localparam int TCS_BIT_SHARED_PSR = 0;

	// clock select field codes
	localparam logic [2:0] TCS_CS_NONE = 3'h0;
	localparam logic [2:0] TCS_CS_DIV1 = 3'h1;
	localparam logic [2:0] TCS_CS_DIV8 = 3'h2;
	localparam logic [2:0] TCS_CS_DIV64 = 3'h3;
	localparam logic [2:0] TCS_CS_DIV256 = 3'h4;
	localparam logic [2:0] TCS_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TCS_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] TCS_CS_EXT_RISE = 3'h7;

	// prescaler geometry: a 10-bit counter with four taps
	localparam int TCS_PRESC_W = 10;
	localparam int TCS_NUM_TAPS = 4;
	localparam int TCS_TAP_BITS [TCS_NUM_TAPS] = '{3, 6, 8, 10};
	localparam int TCS_NUM_SYNC_TIMERS = 2;

	// reset values of internal state
	localparam logic [TCS_PRESC_W-1:0] TCS_PRESC_RESET = 10'h000;
	localparam logic [7:0] TCS_RDATA_RESET = 8'h00;

	// one register access request from the processor core
	typedef struct packed {
		logic [7:0] addr;
		logic io_space;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tcs_bus_req_t;

	// ticks handed to the timer counters
	typedef struct packed {
		logic [TCS_NUM_SYNC_TIMERS-1:0] sync_tick;
		logic async_tick;
	} tcs_ticks_t;

endpackage
